// >>> rtl/ulpi_pwr_consts.svh
// Purpose: Named addresses, field positions and codes for the vendor power-control register path.
// Assumes: Included by the two end modules and by the link checker.
// Notes:   Definitions only.
`ifndef ULPI_PWR_CONSTS_SVH
`define ULPI_PWR_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_EXT_ESCAPE 6'h2F
`define ADDR_VENDOR_LO 8'h30
`define ADDR_VENDOR_HI 8'h3F
`define ADDR_PWR_WRITE 8'h3D
`define ADDR_PWR_SET 8'h3E
`define ADDR_PWR_CLEAR 8'h3F
`define ADDR_EXT_LIMIT 8'h40
`define PWR_RESET_VALUE 8'h00
`define PWR_RSVD_MASK 8'hF0
`define PWR_BIT_PIN_SEL 0
`define PWR_BIT_RISE 2
`define PWR_BIT_FALL 3

// ----------------------------------------------------------------
// Bus codes
// ----------------------------------------------------------------
`define CMD_REG_WRITE 2'h2
`define CMD_REG_READ 2'h3
`define BUS_IDLE_BYTE 8'h00
`define RXCMD_BIT_ALT_INT 7
`define RXCMD_BIT_SESS 3

`endif

// >>> rtl/ulpi_pwr_pkg.sv
// Purpose: State types shared by both ends of the register link.
// Assumes: Nothing beyond the constants header.
// Notes:   Types only; numbers live in the header.
package ulpi_pwr_pkg;

  // ----------------------------------------------------------------
  // Transceiver end states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    P_IDLE = 3'h0,
    P_EXT = 3'h1,
    P_WDATA = 3'h2,
    P_WSTOP = 3'h3,
    P_RTURN = 3'h4,
    P_RDATA = 3'h5,
    P_XTURN = 3'h6,
    P_XDATA = 3'h7
  } phy_state_t;

  // ----------------------------------------------------------------
  // Link end states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    L_IDLE = 3'h0,
    L_CMD = 3'h1,
    L_EXT = 3'h2,
    L_WDATA = 3'h3,
    L_STOP = 3'h4,
    L_RWAIT = 3'h5,
    L_RDATA = 3'h6,
    L_RXCMD = 3'h7
  } link_state_t;

endpackage

// >>> rtl/ulpi_pwr_if.sv
// Purpose: Register link between the link controller and the transceiver.
// Assumes: Both ends run on one clock; the data bus is resolved here.
// Notes:   The bus reads as idle when neither end drives it.
`timescale 1ns/1ps
interface ulpi_pwr_if;
  logic dir;
  logic nxt;
  logic stp;
  logic [7:0] link_data_out;
  logic link_data_oe;
  logic [7:0] phy_data_out;
  logic phy_data_oe;
  logic [7:0] data;

  // Resolve the shared byte lane from the two output enables.
  assign data = link_data_oe ? link_data_out : (phy_data_oe ? phy_data_out : 8'h00);

  modport phy_end (output dir, output nxt, output phy_data_out, output phy_data_oe, input stp, input data);
  modport link_end (output stp, output link_data_out, output link_data_oe, input dir, input nxt, input data);
endinterface

// >>> rtl/sync_edge.sv
// Purpose: Two-stage synchroniser with edge detection for an outside level.
// Assumes: Input is asynchronous to clock.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module sync_edge #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic stage1;
  logic stage2;
  logic stage3;

  // The third stage only remembers the previous settled value for edges.
  always_ff @(posedge clock) begin
    if (rst) begin
      stage1 <= RESET_LEVEL;
      stage2 <= RESET_LEVEL;
      stage3 <= RESET_LEVEL;
    end else if (ce) begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Edges are one-cycle pulses and are gated by the enable so none is seen twice.
  assign level = stage2;
  assign rise = ce & stage2 & ~stage3;
  assign fall = ce & ~stage2 & stage3;
endmodule

// >>> rtl/ulpi_phy_end.sv
// Purpose: Transceiver end of the register link: vendor power-control register,
//          session-valid edge reports and the shared reset / power-switch pin.
// Assumes: The link keeps its own obligations; one clock shared by both ends.
// Notes:   Immediate registers other than the power-control register sit outside
//          this block and read back as zero here.
// What this block does
// - Address 2Fh escapes to extended address byte.
// - Addresses 30h to 3Fh hold vendor registers.
// - Power control: write 3Dh, set 3Eh, clear 3Fh.
// - Link never writes ones to bits 7-4; the link clears them for 3Dh and 3Eh only, not for 3Fh.
// - Enabled falling session edge sends alt-int report.
// - Enabled rising session edge sends alt-int report.
// - Link should prefer comparator events over these.
// - Bit 0 selects reset input or power switch.
// - After reset pin acts as reset input.
// - Ganged power switching needs bit 0 set.
// - Extended 00h-3Fh alias the immediate registers.
// - Link must not touch extended 40h-FFh.
`timescale 1ns/1ps
`include "ulpi_pwr_consts.svh"
module ulpi_phy_end
  import ulpi_pwr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  ulpi_pwr_if.phy_end bus,
  input wire logic b_session_valid,
  input wire logic power_switch_request,
  input wire logic shared_pin_in,
  output logic shared_pin_out,
  output logic shared_pin_oe,
  output logic pin_reset_request,
  output logic [7:0] power_pin_control_value
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // New register value for an access at a given address.
  function automatic logic [7:0] reg_update(input logic [7:0] addr, input logic [7:0] old,
                                            input logic [7:0] wdata);
    logic [7:0] result;
    result = old;
    if (addr == `ADDR_PWR_WRITE) begin
      result = wdata;
    end else if (addr == `ADDR_PWR_SET) begin
      result = old | wdata;
    end else if (addr == `ADDR_PWR_CLEAR) begin
      result = old & ~wdata;
    end
    return result;
  endfunction

  // True when an address selects the power-control register.
  function automatic logic is_power_addr(input logic [7:0] addr);
    return (addr >= `ADDR_PWR_WRITE) && (addr <= `ADDR_PWR_CLEAR);
  endfunction

  // True when the byte on the lane is a register command from the link.
  function automatic logic is_reg_cmd(input logic [7:0] value);
    return (value[7:6] == `CMD_REG_WRITE) || (value[7:6] == `CMD_REG_READ);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  phy_state_t state;
  phy_state_t next_state;
  logic [7:0] power_pin_control;
  logic [7:0] access_addr;
  logic [7:0] access_data;
  logic access_read;
  logic report_pending;
  logic report_event;
  logic [7:0] read_value;
  logic sess_level;
  logic sess_rise;
  logic sess_fall;
  logic pin_level;
  logic cmd_seen;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------

  // Session-valid comes from an analog comparator and is not clock aligned.
  sync_edge #(.RESET_LEVEL(1'b0)) u_sess_sync (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .async_in(b_session_valid),
    .level(sess_level),
    .rise(sess_rise),
    .fall(sess_fall)
  );

  // The shared pin idles high, so its synchroniser resets high to avoid a false reset.
  sync_edge #(.RESET_LEVEL(1'b1)) u_pin_sync (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .async_in(shared_pin_in),
    .level(pin_level),
    .rise(),
    .fall()
  );

  // ----------------------------------------------------------------
  // Bus sequencing
  // ----------------------------------------------------------------
  assign cmd_seen = is_reg_cmd(bus.data);

  // Next state; a link command is taken ahead of a pending report.
  always_comb begin
    next_state = state;
    unique case (state)
      P_IDLE: begin
        if (cmd_seen) begin
          if (bus.data[5:0] == `ADDR_EXT_ESCAPE) begin
            next_state = P_EXT;
          end else if (bus.data[6]) begin
            next_state = P_RTURN;
          end else begin
            next_state = P_WDATA;
          end
        end else if (report_pending) begin
          next_state = P_XTURN;
        end
      end
      P_EXT: begin
        next_state = access_read ? P_RTURN : P_WDATA;
      end
      P_WDATA: begin
        next_state = P_WSTOP;
      end
      P_WSTOP: begin
        if (bus.stp) begin
          next_state = P_IDLE;
        end
      end
      P_RTURN: begin
        next_state = P_RDATA;
      end
      P_RDATA: begin
        next_state = P_IDLE;
      end
      P_XTURN: begin
        next_state = P_XDATA;
      end
      P_XDATA: begin
        next_state = P_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= P_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Accepts a byte in the same cycle it appears; the link waits only while a report owns the lane.
  assign bus.nxt = ((state == P_IDLE) && cmd_seen) || (state == P_EXT) || (state == P_WDATA);
  assign bus.dir = (state == P_RTURN) || (state == P_RDATA) || (state == P_XTURN) || (state == P_XDATA);
  assign bus.phy_data_oe = (state == P_RDATA) || (state == P_XDATA);

  // Capture the address and data of the access in progress.
  always_ff @(posedge clock) begin
    if (rst) begin
      access_addr <= `BUS_IDLE_BYTE;
      access_data <= `BUS_IDLE_BYTE;
      access_read <= 1'b0;
    end else if (ce) begin
      if ((state == P_IDLE) && cmd_seen) begin
        access_addr <= {2'h0, bus.data[5:0]};
        access_read <= bus.data[6];
      end else if (state == P_EXT) begin
        access_addr <= bus.data;
      end else if (state == P_WDATA) begin
        access_data <= bus.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power-control register
  // ----------------------------------------------------------------

  // Committed on the stop strobe; extended addresses share the immediate decode,
  // and addresses from 40h up decode to nothing here.
  always_ff @(posedge clock) begin
    if (rst) begin
      power_pin_control <= `PWR_RESET_VALUE;
    end else if (ce && (state == P_WSTOP) && bus.stp) begin
      power_pin_control <= reg_update(access_addr, power_pin_control, access_data);
    end
  end

  // Reads of the rest of the vendor range return zero; no other register lives there.
  always_comb begin
    read_value = `BUS_IDLE_BYTE;
    if (is_power_addr(access_addr)) begin
      read_value = power_pin_control;
    end else if ((access_addr >= `ADDR_VENDOR_LO) && (access_addr <= `ADDR_VENDOR_HI)) begin
      read_value = `BUS_IDLE_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // Session-valid edge reports
  // ----------------------------------------------------------------
  assign report_event = (sess_fall & power_pin_control[`PWR_BIT_FALL])
                      | (sess_rise & power_pin_control[`PWR_BIT_RISE]);

  // A new edge in the cycle the report goes out keeps the flag set.
  always_ff @(posedge clock) begin
    if (rst) begin
      report_pending <= 1'b0;
    end else if (ce) begin
      report_pending <= report_event | (report_pending & (state != P_XDATA));
    end
  end

  // Load the byte the transceiver will drive after the turnaround cycle.
  always_ff @(posedge clock) begin
    if (rst) begin
      bus.phy_data_out <= `BUS_IDLE_BYTE;
    end else if (ce) begin
      if (state == P_RTURN) begin
        bus.phy_data_out <= read_value;
      end else if (state == P_XTURN) begin
        bus.phy_data_out <= `BUS_IDLE_BYTE;
        bus.phy_data_out[`RXCMD_BIT_ALT_INT] <= 1'b1;
        bus.phy_data_out[`RXCMD_BIT_SESS] <= sess_level;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared reset / power-switch pin
  // ----------------------------------------------------------------

  // Open drain: only ever pulls low, and only in power-switch mode.
  always_ff @(posedge clock) begin
    if (rst) begin
      shared_pin_oe <= 1'b0;
      pin_reset_request <= 1'b0;
    end else if (ce) begin
      shared_pin_oe <= power_pin_control[`PWR_BIT_PIN_SEL] & power_switch_request;
      pin_reset_request <= ~power_pin_control[`PWR_BIT_PIN_SEL] & ~pin_level;
    end
  end

  assign shared_pin_out = 1'b0;
  assign power_pin_control_value = power_pin_control;

endmodule

// >>> rtl/ulpi_link_end.sv
// Purpose: Link-controller end: turns user register requests into bus transfers
//          and passes transceiver reports to the user.
// Assumes: One clock shared with the transceiver end.
// Notes:   Extended addresses from 40h up are refused locally.
`timescale 1ns/1ps
`include "ulpi_pwr_consts.svh"
module ulpi_link_end
  import ulpi_pwr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  ulpi_pwr_if.link_end bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ext,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic ganged_power,
  output logic req_ready,
  output logic resp_valid,
  output logic resp_err,
  output logic [7:0] resp_data,
  output logic report_valid,
  output logic [7:0] report_data
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Clean a write byte before it leaves the link.
  function automatic logic [7:0] shape_write(input logic [7:0] addr, input logic [7:0] wdata,
                                             input logic ganged);
    logic [7:0] result;
    result = wdata;
    if ((addr == `ADDR_PWR_WRITE) || (addr == `ADDR_PWR_SET)) begin
      result = wdata & ~`PWR_RSVD_MASK;
      if (ganged) begin
        result[`PWR_BIT_PIN_SEL] = 1'b1;
      end
    end else if ((addr == `ADDR_PWR_CLEAR) && ganged) begin
      result[`PWR_BIT_PIN_SEL] = 1'b0;
    end
    return result;
  endfunction

  link_state_t state;
  logic use_ext;
  logic is_write;
  logic cmd_held;
  logic [7:0] target_addr;
  logic [7:0] write_byte;
  logic refuse;

  // Refusal is decided before anything reaches the bus.
  assign refuse = req_ext & (req_addr >= `ADDR_EXT_LIMIT);
  assign req_ready = (state == L_IDLE) & ~bus.dir;
  assign bus.stp = (state == L_STOP);
  assign bus.link_data_oe = ~bus.dir & ((state == L_CMD) | (state == L_EXT) | (state == L_WDATA) | (state == L_STOP));

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------

  // A report can arrive while a command waits; the command is held and retried.
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= L_IDLE;
      cmd_held <= 1'b0;
      use_ext <= 1'b0;
      is_write <= 1'b0;
      target_addr <= `BUS_IDLE_BYTE;
      write_byte <= `BUS_IDLE_BYTE;
      bus.link_data_out <= `BUS_IDLE_BYTE;
    end else if (ce) begin
      unique case (state)
        L_IDLE: begin
          if (bus.dir) begin
            state <= L_RXCMD;
          end else if (req_valid && !refuse) begin
            use_ext <= req_ext;
            is_write <= req_write;
            target_addr <= req_addr;
            write_byte <= shape_write(req_addr, req_data, ganged_power);
            cmd_held <= 1'b1;
            bus.link_data_out <= {(req_write ? `CMD_REG_WRITE : `CMD_REG_READ),
                                  (req_ext ? `ADDR_EXT_ESCAPE : req_addr[5:0])};
            state <= L_CMD;
          end
        end
        L_CMD: begin
          if (bus.nxt) begin
            if (use_ext) begin
              bus.link_data_out <= target_addr;
              state <= L_EXT;
            end else if (is_write) begin
              bus.link_data_out <= write_byte;
              state <= L_WDATA;
            end else begin
              bus.link_data_out <= `BUS_IDLE_BYTE;
              state <= L_RWAIT;
            end
          end else if (bus.dir) begin
            state <= L_RXCMD;
          end
        end
        L_EXT: begin
          if (bus.nxt) begin
            bus.link_data_out <= is_write ? write_byte : `BUS_IDLE_BYTE;
            state <= is_write ? L_WDATA : L_RWAIT;
          end
        end
        L_WDATA: begin
          if (bus.nxt) begin
            bus.link_data_out <= `BUS_IDLE_BYTE;
            state <= L_STOP;
          end
        end
        L_STOP: begin
          cmd_held <= 1'b0;
          state <= L_IDLE;
        end
        L_RWAIT: begin
          if (bus.dir) begin
            state <= L_RDATA;
          end
        end
        L_RDATA: begin
          cmd_held <= 1'b0;
          state <= L_IDLE;
        end
        L_RXCMD: begin
          state <= cmd_held ? L_CMD : L_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // User answers
  // ----------------------------------------------------------------

  // Session reports are forwarded as-is; deciding on them is left to software.
  always_ff @(posedge clock) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_err <= 1'b0;
      resp_data <= `BUS_IDLE_BYTE;
      report_valid <= 1'b0;
      report_data <= `BUS_IDLE_BYTE;
    end else if (ce) begin
      resp_valid <= (state == L_STOP) | (state == L_RDATA) | (req_ready & req_valid & refuse);
      resp_err <= req_ready & req_valid & refuse;
      if (state == L_RDATA) begin
        resp_data <= bus.data;
      end
      report_valid <= (state == L_RXCMD);
      if (state == L_RXCMD) begin
        report_data <= bus.data;
      end
    end
  end

endmodule

// >>> verif/ulpi_pwr_link_sva.sv
// Purpose: Protocol checks on the register link between the two ends.
// Assumes: One clock; reset is synchronous and active high.
// Notes:   Sees only the interface signals; register contents are judged by the bench.
`timescale 1ns/1ps
`include "ulpi_pwr_consts.svh"
module ulpi_pwr_link_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic dir,
  input wire logic nxt,
  input wire logic stp,
  input wire logic [7:0] link_data_out,
  input wire logic link_data_oe,
  input wire logic [7:0] phy_data_out,
  input wire logic phy_data_oe,
  input wire logic [7:0] data
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // A command byte counts only when the link owns the lane and it is accepted.
  logic cmd_taken;
  logic is_ext;
  assign cmd_taken = nxt && !dir && link_data_oe;
  assign is_ext = (data[5:0] == `ADDR_EXT_ESCAPE);

  // Data byte accepted, then the stop cycle.
  sequence s_write_tail;
    nxt ##1 (stp && !dir);
  endsequence

  // Turnaround, transceiver drives the value, then the lane returns.
  sequence s_read_tail;
    dir ##1 (dir && phy_data_oe) ##1 !dir;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_IMM_WRITE: assert property (cmd_taken && data[7:6] == `CMD_REG_WRITE && !is_ext |=> s_write_tail)
    else $error("immediate write framing wrong");
  AST_EXT_WRITE: assert property (cmd_taken && data[7:6] == `CMD_REG_WRITE && is_ext |=> nxt ##1 s_write_tail)
    else $error("extended write framing wrong");
  AST_IMM_READ: assert property (cmd_taken && data[7:6] == `CMD_REG_READ && !is_ext |=> s_read_tail)
    else $error("immediate read framing wrong");
  AST_EXT_READ: assert property (cmd_taken && data[7:6] == `CMD_REG_READ && is_ext |=> nxt ##1 s_read_tail)
    else $error("extended read framing wrong");
  AST_EXT_RANGE: assert property (cmd_taken && data[7] && is_ext |=> data[7:6] == 2'h0)
    else $error("extended address above implemented range");
  AST_RSVD_BITS: assert property (cmd_taken && (data == 8'hBD || data == 8'hBE) |=> data[7:4] == 4'h0)
    else $error("ones written into reserved bits");
  AST_REPORT: assert property ($rose(dir) && !$past(nxt) |=> dir && phy_data_oe && data[`RXCMD_BIT_ALT_INT])
    else $error("report byte lacks alt-int flag");
  AST_STOP_PULSE: assert property (stp |-> !dir && $past(nxt) ##1 !stp)
    else $error("stop not a single cycle after data");
endmodule

// >>> verif/ulpi_vendor_power_control_regs_test.sv
// Purpose: Self-checking bench joining both ends through the link interface.
// Assumes: Requests are issued one at a time through the user side of the link end.
// Notes:   Expected register values are worked out here, not read from the design.
`timescale 1ns/1ps
module ulpi_vendor_power_control_regs_test
  import ulpi_pwr_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic b_session_valid = 1'b0;
  logic power_switch_request = 1'b0;
  logic shared_pin_in = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_ext = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_data = 8'h00;
  logic ganged_power = 1'b0;
  logic shared_pin_out, shared_pin_oe, pin_reset_request, req_ready, resp_valid, resp_err, report_valid;
  logic [7:0] power_pin_control_value, resp_data, report_data, rd_data;
  logic rd_err;
  int errors = 0;
  int samples_checked = 0;

  // Free-running 250 MHz clock.
  always #2 clock = ~clock;

  // ----------------------------------------------------------------
  // Both ends and the checker on the shared link
  // ----------------------------------------------------------------
  ulpi_pwr_if bus_if();
  ulpi_phy_end i_ulpi_phy_end (.clock(clock), .rst(rst), .ce(ce), .bus(bus_if), .b_session_valid(b_session_valid),
    .power_switch_request(power_switch_request), .shared_pin_in(shared_pin_in), .shared_pin_out(shared_pin_out),
    .shared_pin_oe(shared_pin_oe), .pin_reset_request(pin_reset_request),
    .power_pin_control_value(power_pin_control_value));
  ulpi_link_end i_ulpi_link_end (.clock(clock), .rst(rst), .ce(ce), .bus(bus_if), .req_valid(req_valid),
    .req_write(req_write), .req_ext(req_ext), .req_addr(req_addr), .req_data(req_data), .ganged_power(ganged_power),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_err(resp_err), .resp_data(resp_data),
    .report_valid(report_valid), .report_data(report_data));
  ulpi_pwr_link_sva i_ulpi_pwr_link_sva (.clock(clock), .rst(rst), .dir(bus_if.dir), .nxt(bus_if.nxt),
    .stp(bus_if.stp), .link_data_out(bus_if.link_data_out), .link_data_oe(bus_if.link_data_oe),
    .phy_data_out(bus_if.phy_data_out), .phy_data_oe(bus_if.phy_data_oe), .data(bus_if.data));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One request: held until ready was high at the taking edge, then wait for the answer.
  task automatic xfer(input logic w, input logic e, input logic [7:0] a, input logic [7:0] d);
    int n;
    logic t;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= w;
    req_ext <= e;
    req_addr <= a;
    req_data <= d;
    do begin
      #1 t = req_ready;
      @(posedge clock);
      n++;
    end while (t !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    n = 0;
    // A refused request answers at the taking edge itself, so look before waiting.
    #1;
    while (resp_valid !== 1'b1 && n < 50) begin
      @(posedge clock);
      #1 n++;
    end
    if (n >= 50) begin
      errors++;
    end
    rd_data = resp_data;
    rd_err = resp_err;
  endtask

  // Operation, then read back through all three power-control addresses.
  task automatic op_chk(input logic w, input logic e, input logic [7:0] a, input logic [7:0] d, input logic [7:0] x);
    for (int i = 0; i < 3; i++) begin
      if (i == 0) begin
        xfer(w, e, a, d);
      end
      xfer(1'b0, e, 8'h3D + 8'(i), 8'h00);
      chk("readback", rd_data, x);
    end
    chk("register", power_pin_control_value, x);
    chk("resp_err", {7'h00, rd_err}, 8'h00);
  endtask

  // Count reports over a fixed window; a report is late if it misses it.
  task automatic rep(input logic [7:0] d, input int n);
    int c;
    c = 0;
    repeat (30) begin
      @(posedge clock);
      #1 if (report_valid === 1'b1) begin
        c++;
        chk("report_data", report_data, d);
      end
    end
    chk("report_count", 8'(c), 8'(n));
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs about five hundred cycles.
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    test_done;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    #1 chk("pin_reset_request", {7'h00, pin_reset_request}, 8'h01);
    chk("pin_oe", {7'h00, shared_pin_oe}, 8'h00);
    chk("pin_out", {7'h00, shared_pin_out}, 8'h00);
    op_chk(1'b0, 1'b0, 8'h3D, 8'h00, 8'h00);
    op_chk(1'b1, 1'b0, 8'h3D, 8'h05, 8'h05);
    op_chk(1'b1, 1'b0, 8'h3E, 8'h08, 8'h0D);
    op_chk(1'b1, 1'b0, 8'h3F, 8'h05, 8'h08);
    op_chk(1'b1, 1'b1, 8'h3D, 8'h0C, 8'h0C);
    op_chk(1'b1, 1'b1, 8'h3E, 8'h01, 8'h0D);
    op_chk(1'b1, 1'b1, 8'h3F, 8'h01, 8'h0C);
    op_chk(1'b1, 1'b0, 8'h30, 8'h0F, 8'h0C);
    xfer(1'b0, 1'b1, 8'h40, 8'h00);
    chk("ext_err_40", {7'h00, rd_err}, 8'h01);
    xfer(1'b1, 1'b1, 8'hFF, 8'h00);
    chk("ext_err_ff", {7'h00, rd_err}, 8'h01);
    // Both edge reports enabled, then the falling one only.
    @(posedge clock) b_session_valid <= 1'b1;
    rep(8'h88, 1);
    @(posedge clock) b_session_valid <= 1'b0;
    rep(8'h80, 1);
    op_chk(1'b1, 1'b0, 8'h3F, 8'h04, 8'h08);
    @(posedge clock) b_session_valid <= 1'b1;
    rep(8'h88, 0);
    @(posedge clock) b_session_valid <= 1'b0;
    rep(8'h80, 1);
    // Power-switch mode: the pin follows the request and no reset is reported.
    op_chk(1'b1, 1'b0, 8'h3D, 8'h01, 8'h01);
    // A low enable holds the pin drive back until it returns.
    @(posedge clock) {ce, power_switch_request} <= 2'h1;
    repeat (4) @(posedge clock);
    #1 chk("pin_oe_frozen", {7'h00, shared_pin_oe}, 8'h00);
    @(posedge clock) ce <= 1'b1;
    repeat (4) @(posedge clock);
    #1 chk("pin_oe", {7'h00, shared_pin_oe}, 8'h01);
    chk("pin_reset_request", {7'h00, pin_reset_request}, 8'h00);
    @(posedge clock) power_switch_request <= 1'b0;
    repeat (3) @(posedge clock);
    #1 chk("pin_oe", {7'h00, shared_pin_oe}, 8'h00);
    op_chk(1'b1, 1'b0, 8'h3F, 8'h01, 8'h00);
    repeat (4) @(posedge clock);
    #1 chk("pin_reset_request", {7'h00, pin_reset_request}, 8'h01);
    @(posedge clock) shared_pin_in <= 1'b1;
    repeat (4) @(posedge clock);
    #1 chk("pin_reset_idle", {7'h00, pin_reset_request}, 8'h00);
    // Ganged wiring keeps the select bit; reserved bits never leave the link on a write or set.
    @(posedge clock) ganged_power <= 1'b1;
    op_chk(1'b1, 1'b0, 8'h3D, 8'h04, 8'h05);
    op_chk(1'b1, 1'b0, 8'h3F, 8'h05, 8'h01);
    @(posedge clock) ganged_power <= 1'b0;
    op_chk(1'b1, 1'b0, 8'h3D, 8'hF4, 8'h04);
    // A second reset in mid-run brings every bit back to zero.
    @(posedge clock) rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    op_chk(1'b0, 1'b0, 8'h3D, 8'h00, 8'h00);
    test_done;
  end
endmodule
